// File: hw/iomx_pin_mux.v
// Pin function multiplexer, JTAG takeover and pad defaults
`timescale 1ns/100ps
`default_nettype none
`include "iomx_defines.vh"

// Function
// - Trace enabled: trace unit drives serial trace on PA23, overriding everything.
// - After reset release, debug pins become JTAG on TCK rising edge.
// - TMS and TDI pull-ups enabled while the debug pins serve JTAG.
// - TCK pull-up stays enabled throughout reset.
// - JTAG disabled: debug pins act as normal GPIO or peripheral pins.
// - Two-wire lines drive open-drain; otherwise ordinary push-pull lines.
// - Every line has its own pull-up, pull-down and slew control.
// - On reset lines are inputs, pulls off except the TCK pull-up, slew limiting on.
// - Oscillator pins bypass the mux, routed only by system control.
// - Port B line 0 is line 32: A two-wire data, B serial rx.
// - Line 4: A analog input 0, B serial clock, C irq line 2.
// - Ports A 0..31, B 0..15, C 0..31, all bidirectional lines.
// - USB lines follow USB signalling when assigned, else normal I/O.
// - First GPIO interrupt output drives interrupt request line 25.
module iomx_pin_mux (
    // Clock and reset
    input wire i_clk,
    input wire i_resetn,
    // Package pads
    input wire [`IOMX_NLINES-1:0] i_pad_in,
    output reg [`IOMX_NLINES-1:0] o_pad_out,
    output reg [`IOMX_NLINES-1:0] o_pad_oe_n,
    output reg [`IOMX_NLINES-1:0] o_pad_pullup,
    output reg [`IOMX_NLINES-1:0] o_pad_pulldown,
    output reg [`IOMX_NLINES-1:0] o_pad_slew,
    // GPIO controller
    input wire [`IOMX_NLINES-1:0] i_gpio_out,
    input wire [`IOMX_NLINES-1:0] i_gpio_oe,
    input wire [`IOMX_NLINES-1:0] i_gpio_periph_en,
    input wire [`IOMX_NLINES*`IOMX_SELW-1:0] i_gpio_func_sel,
    input wire [`IOMX_NLINES-1:0] i_gpio_pullup,
    input wire [`IOMX_NLINES-1:0] i_gpio_pulldown,
    input wire [`IOMX_NLINES-1:0] i_gpio_slew,
    output reg [`IOMX_NLINES-1:0] o_gpio_in,
    input wire i_gpio_irq0,
    // Interrupt controller
    output reg o_irq_line25,
    // Trace unit
    input wire i_trace_en,
    input wire i_trace_swo,
    // Debug port
    input wire i_jtag_enable,
    input wire i_jtag_tdo,
    input wire i_jtag_tdo_oe,
    output reg o_jtag_active,
    output reg o_jtag_tck,
    output reg o_jtag_tms,
    output reg o_jtag_tdi,
    // System control oscillator routing
    input wire i_main_osc_route,
    input wire i_main_osc_out,
    output reg o_main_osc_in,
    // USB controller
    input wire i_usb_en,
    input wire i_usb_dp_out,
    input wire i_usb_dm_out,
    input wire i_usb_oe,
    output reg o_usb_dp_in,
    output reg o_usb_dm_in,
    // Two-wire unit 1
    input wire i_two_wire_data_out,
    input wire i_two_wire_data_oe,
    output reg o_two_wire_data_in,
    // Serial port 0
    input wire i_serial_port0_clk_out,
    input wire i_serial_port0_clk_oe,
    output reg o_serial_port0_clk_in,
    output reg o_serial_port0_rxd,
    // Analog front end and external interrupt controller
    output reg o_analog_input0_sel,
    output reg o_ext_irq_line2
);

    // Two-stage pad synchroniser; only pad_sync is read by logic
    reg [`IOMX_NLINES-1:0] pad_meta;
    reg [`IOMX_NLINES-1:0] pad_sync;

    // Debug takeover state
    reg tck_prev;
    reg tck_rise;
    reg jtag_active;

    // Combinational pad controls, registered below
    reg [`IOMX_NLINES-1:0] next_out;
    reg [`IOMX_NLINES-1:0] next_drv;
    reg [`IOMX_NLINES-1:0] next_pullup;

    // Decoded function slots
    reg sel_twd_a;
    reg sel_rxd_b;
    reg sel_ain0_a;
    reg sel_clk_b;
    reg sel_irq2_c;
    integer i;

    // Selector field of one line
    // Three bits per line, line 0 in the lowest bits
    function [`IOMX_SELW-1:0] line_sel;
        input [`IOMX_NLINES*`IOMX_SELW-1:0] sels;
        input integer line;
        begin
            line_sel = sels[line*`IOMX_SELW +: `IOMX_SELW];
        end
    endfunction

    // True when a line is handed to a peripheral with the given function
    function periph_func;
        input [`IOMX_NLINES-1:0] en;
        input [`IOMX_NLINES*`IOMX_SELW-1:0] sels;
        input integer line;
        input [`IOMX_SELW-1:0] func;
        begin
            periph_func = en[line] && (line_sel(sels, line) == func);
        end
    endfunction

    // Decoded function slots actually populated on this block
    always @* begin
        // Synchronised TCK low last cycle and high now
        tck_rise = !tck_prev && pad_sync[`IOMX_LINE_TCK];
        sel_twd_a = periph_func(i_gpio_periph_en, i_gpio_func_sel,
            `IOMX_LINE_TWD, `IOMX_FUNC_A);
        sel_rxd_b = periph_func(i_gpio_periph_en, i_gpio_func_sel,
            `IOMX_LINE_TWD, `IOMX_FUNC_B);
        sel_ain0_a = periph_func(i_gpio_periph_en, i_gpio_func_sel,
            `IOMX_LINE_AIN0, `IOMX_FUNC_A);
        sel_clk_b = periph_func(i_gpio_periph_en, i_gpio_func_sel,
            `IOMX_LINE_AIN0, `IOMX_FUNC_B);
        sel_irq2_c = periph_func(i_gpio_periph_en, i_gpio_func_sel,
            `IOMX_LINE_AIN0, `IOMX_FUNC_C);
    end

    // Pad drive resolution, lowest priority first so later wins
    // Order: slot, USB, JTAG, oscillator, trace
    always @* begin
        next_out = `IOMX_RST_OUT;
        next_drv = `IOMX_RST_OUT;
        next_pullup = i_gpio_pullup;
        for (i = 0; i < `IOMX_NLINES; i = i + 1) begin
            if (!i_gpio_periph_en[i]) begin
                // Plain GPIO: controller owns value and enable
                next_out[i] = i_gpio_out[i];
                next_drv[i] = i_gpio_oe[i];
            end
            // A peripheral slot with nothing behind it stays undriven
        end

        // Two-wire data: only ever pulls low, never drives high
        if (sel_twd_a) begin
            next_out[`IOMX_LINE_TWD] = 1'b0;
            next_drv[`IOMX_LINE_TWD] = i_two_wire_data_oe &
                ~i_two_wire_data_out;
        end

        // Serial port 0 clock is push-pull on line 4 function B
        if (sel_clk_b) begin
            next_out[`IOMX_LINE_AIN0] = i_serial_port0_clk_out;
            next_drv[`IOMX_LINE_AIN0] = i_serial_port0_clk_oe;
        end

        // USB lines belong to the USB controller while it is enabled
        if (i_usb_en) begin
            next_out[`IOMX_LINE_USB_DP] = i_usb_dp_out;
            next_out[`IOMX_LINE_USB_DM] = i_usb_dm_out;
            next_drv[`IOMX_LINE_USB_DP] = i_usb_oe;
            next_drv[`IOMX_LINE_USB_DM] = i_usb_oe;
        end

        // Debug port takeover; released again once JTAG is disabled
        // TCK, TMS and TDI turn inputs; TDO follows the debug port
        if (jtag_active) begin
            next_drv[`IOMX_LINE_TCK] = 1'b0;
            next_drv[`IOMX_LINE_TMS] = 1'b0;
            next_drv[`IOMX_LINE_TDI] = 1'b0;
            next_out[`IOMX_LINE_TDO] = i_jtag_tdo;
            next_drv[`IOMX_LINE_TDO] = i_jtag_tdo_oe;
            next_pullup[`IOMX_LINE_TMS] = 1'b1;
            next_pullup[`IOMX_LINE_TDI] = 1'b1;
        end

        // Oscillator routing sits outside the function selectors
        if (i_main_osc_route) begin
            next_drv[`IOMX_LINE_OSC_IN] = 1'b0;
            next_out[`IOMX_LINE_OSC_IN] = 1'b0;
            next_out[`IOMX_LINE_OSC_OUT] = i_main_osc_out;
            next_drv[`IOMX_LINE_OSC_OUT] = 1'b1;
        end

        // Trace wins over every other owner of its line
        if (i_trace_en) begin
            next_out[`IOMX_LINE_TRACE] = i_trace_swo;
            next_drv[`IOMX_LINE_TRACE] = 1'b1;
        end
    end

    // Input synchroniser for all 80 pads of ports A, B and C
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            // TCK starts high as its reset pull-up holds it, so the
            // first samples after release never fake a rising edge
            pad_meta <= `IOMX_RST_PULLUP;
            pad_sync <= `IOMX_RST_PULLUP;
        end else begin
            pad_meta <= i_pad_in;
            pad_sync <= pad_meta;
        end
    end

    // JTAG takeover on a synchronised TCK rising edge after reset
    // Enable low drops the takeover, handing the pins back to the mux
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            tck_prev <= 1'b1;
            jtag_active <= 1'b0;
        end else begin
            tck_prev <= pad_sync[`IOMX_LINE_TCK];
            if (!i_jtag_enable) begin
                jtag_active <= 1'b0;
            end else if (tck_rise) begin
                jtag_active <= 1'b1;
            end
        end
    end

    // Registered pad controls; reset leaves every line a quiet input
    // Pulldown and slew pass straight from the GPIO controller
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_pad_out <= `IOMX_RST_OUT;
            o_pad_oe_n <= `IOMX_RST_OE_N;
            o_pad_pullup <= `IOMX_RST_PULLUP;
            o_pad_pulldown <= `IOMX_RST_PULLDN;
            o_pad_slew <= `IOMX_RST_SLEW;
        end else begin
            o_pad_out <= next_out;
            o_pad_oe_n <= ~next_drv; // Low while driving
            o_pad_pullup <= next_pullup;
            o_pad_pulldown <= i_gpio_pulldown;
            o_pad_slew <= i_gpio_slew;
        end
    end

    // Inputs fanned out to the GPIO controller and peripherals
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_gpio_in <= `IOMX_RST_OUT;
            o_irq_line25 <= 1'b0;
            o_jtag_active <= 1'b0;
            o_jtag_tck <= 1'b0;
            o_jtag_tms <= 1'b0;
            o_jtag_tdi <= 1'b0;
            o_main_osc_in <= 1'b0;
            o_usb_dp_in <= 1'b0;
            o_usb_dm_in <= 1'b0;
            o_two_wire_data_in <= 1'b1;
            o_serial_port0_clk_in <= 1'b0;
            o_serial_port0_rxd <= 1'b1;
            o_analog_input0_sel <= 1'b0;
            o_ext_irq_line2 <= 1'b0;
        end else begin
            // GPIO always sees the pad, even on an empty slot
            o_gpio_in <= pad_sync;
            o_irq_line25 <= i_gpio_irq0;
            o_jtag_active <= jtag_active;

            // Debug inputs read as idle unless JTAG owns the pins
            o_jtag_tck <= jtag_active & pad_sync[`IOMX_LINE_TCK];
            o_jtag_tms <= jtag_active & pad_sync[`IOMX_LINE_TMS];
            o_jtag_tdi <= jtag_active & pad_sync[`IOMX_LINE_TDI];
            // Oscillator input only while the routing selects it
            o_main_osc_in <= i_main_osc_route &
                pad_sync[`IOMX_LINE_OSC_IN];
            // USB receive only while USB owns its lines
            o_usb_dp_in <= i_usb_en & pad_sync[`IOMX_LINE_USB_DP];
            o_usb_dm_in <= i_usb_en & pad_sync[`IOMX_LINE_USB_DM];

            // Idle-high buses read high when not routed
            o_two_wire_data_in <= ~sel_twd_a |
                pad_sync[`IOMX_LINE_TWD];
            o_serial_port0_rxd <= ~sel_rxd_b |
                pad_sync[`IOMX_LINE_TWD];
            // Line 4 inputs follow the selected function
            o_serial_port0_clk_in <= sel_clk_b &
                pad_sync[`IOMX_LINE_AIN0];
            o_analog_input0_sel <= sel_ain0_a;
            o_ext_irq_line2 <= sel_irq2_c &
                pad_sync[`IOMX_LINE_AIN0];
        end
    end

endmodule
`default_nettype wire

// File: hw/iomx_defines.vh
// Shared constants for the I/O pin function multiplexer
`ifndef IOMX_DEFINES_VH
`define IOMX_DEFINES_VH

// Line counts: port A 0..31, port B 32..47, port C 48..79
`define IOMX_NLINES 80
`define IOMX_PORTA_BASE 0
`define IOMX_PORTB_BASE 32
`define IOMX_PORTC_BASE 48
`define IOMX_SELW 3

// Peripheral function codes in each 3-bit selector
`define IOMX_FUNC_A 3'h0
`define IOMX_FUNC_B 3'h1
`define IOMX_FUNC_C 3'h2
`define IOMX_FUNC_D 3'h3
`define IOMX_FUNC_E 3'h4
`define IOMX_FUNC_F 3'h5
`define IOMX_FUNC_G 3'h6

// Fixed line positions
`define IOMX_LINE_OSC_IN 0
`define IOMX_LINE_OSC_OUT 1
`define IOMX_LINE_AIN0 4
`define IOMX_LINE_TRACE 23
`define IOMX_LINE_USB_DM 25
`define IOMX_LINE_USB_DP 26
`define IOMX_LINE_TWD 32
`define IOMX_LINE_TCK 40
`define IOMX_LINE_TMS 41
`define IOMX_LINE_TDI 42
`define IOMX_LINE_TDO 43

// Reset values of the pad control vectors
`define IOMX_RST_PULLUP 80'h0000_0000_0100_0000_0000
`define IOMX_RST_PULLDN 80'h0000_0000_0000_0000_0000
`define IOMX_RST_SLEW 80'hffff_ffff_ffff_ffff_ffff
`define IOMX_RST_OE_N 80'hffff_ffff_ffff_ffff_ffff
`define IOMX_RST_OUT 80'h0000_0000_0000_0000_0000

`endif

// File: bench/iomx_pin_mux_monitor.sv
// Concurrent checks on the pin function multiplexer ports
`timescale 1ns/100ps
`default_nettype none
module iomx_mux_chk (
    // Clock and reset
    input wire i_clk,
    input wire i_resetn,
    // Pad and GPIO vectors
    input wire [79:0] i_gpio_pulldown, i_gpio_slew, i_gpio_oe,
    input wire [79:0] i_gpio_periph_en, o_pad_pullup, o_pad_pulldown,
    input wire [79:0] o_pad_slew, o_pad_oe_n, o_pad_out,
    input wire [239:0] i_gpio_func_sel,
    // Single-bit controls
    input wire i_gpio_irq0, o_irq_line25, i_trace_en, i_trace_swo,
    input wire o_jtag_active, i_jtag_enable,
    input wire i_two_wire_data_oe, i_two_wire_data_out
);
    // Open drain only ever pulls low, so a driven one means release
    wire od_drv = i_two_wire_data_oe & ~i_two_wire_data_out;
    wire twd_a = i_gpio_periph_en[32] & (i_gpio_func_sel[98:96] == 3'h0);
    wire l5_empty = i_gpio_periph_en[5] & (i_gpio_func_sel[17:15] == 3'h7);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    a_trace_owns_pad: assert property (i_trace_en |=>
        !o_pad_oe_n[23] && o_pad_out[23] == $past(i_trace_swo))
        else $error("trace pad wrong");
    a_reset_pad_state: assert property (disable iff (1'h0)
        !i_resetn |=> &o_pad_oe_n && &o_pad_slew && o_pad_pulldown == 80'h0
        && o_pad_pullup == (80'h1 << 40)) else $error("reset pad state");
    a_pad_ctrl_copy: assert property (i_resetn |=>
        o_pad_pulldown == $past(i_gpio_pulldown)
        && o_pad_slew == $past(i_gpio_slew))
        else $error("pad control copy");
    a_irq_one_late: assert property (i_resetn |=>
        o_irq_line25 == $past(i_gpio_irq0)) else $error("irq line");
    a_jtag_pullups: assert property (o_jtag_active |->
        o_pad_pullup[42:41] == 2'h3) else $error("jtag pull-ups");
    a_jtag_drops: assert property (!i_jtag_enable |->
        ##2 !o_jtag_active) else $error("jtag stays active");
    a_gpio_drives: assert property (!i_gpio_periph_en[5] |=>
        o_pad_oe_n[5] == !$past(i_gpio_oe[5])) else $error("gpio drive");
    a_empty_slot_off: assert property (l5_empty |=>
        o_pad_oe_n[5] && !o_pad_out[5]) else $error("empty slot drives");
    a_open_drain_only: assert property (twd_a |=> !o_pad_out[32]
        && o_pad_oe_n[32] == !$past(od_drv)) else $error("open drain");
    c_jtag: cover property (o_jtag_active);
    c_trace: cover property (i_trace_en);
    c_od_low: cover property (twd_a && od_drv);
endmodule
bind iomx_pin_mux iomx_mux_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_gpio_pulldown(i_gpio_pulldown), .i_gpio_slew(i_gpio_slew),
    .i_gpio_oe(i_gpio_oe), .i_gpio_periph_en(i_gpio_periph_en),
    .o_pad_pullup(o_pad_pullup), .o_pad_pulldown(o_pad_pulldown),
    .o_pad_slew(o_pad_slew), .o_pad_oe_n(o_pad_oe_n), .o_pad_out(o_pad_out),
    .i_gpio_func_sel(i_gpio_func_sel), .i_gpio_irq0(i_gpio_irq0),
    .o_irq_line25(o_irq_line25), .i_trace_en(i_trace_en),
    .i_trace_swo(i_trace_swo), .o_jtag_active(o_jtag_active),
    .i_jtag_enable(i_jtag_enable), .i_two_wire_data_oe(i_two_wire_data_oe),
    .i_two_wire_data_out(i_two_wire_data_out));
`default_nettype wire

// File: bench/iomx_pad_model.sv
// Board and pad model: resolves chip drive, board drive and pulls
`timescale 1ns/100ps
`default_nettype none
module iomx_pad_model (
    // Clock for the floating pattern
    input wire i_clk,
    // Chip pad controls and board drivers
    input wire [79:0] i_out, i_oe_n, i_pullup, i_pulldown,
    input wire [79:0] i_ext, i_ext_en,
    // Resolved pad levels
    output wire [79:0] o_level
);
    logic [79:0] flt = 80'h0;
    // Floating lines toggle so a stale level never passes a check
    always @(posedge i_clk) begin
        flt <= ~flt;
    end
    // Two-wire data line carries a bus pull-up on the board
    wire [79:0] pu = i_pullup | (80'h1 << 32);
    // Chip first, then board, then pulls; every line is two-way
    assign o_level = ~i_oe_n & i_out | i_oe_n & (i_ext_en & i_ext
        | ~i_ext_en & (pu | ~i_pulldown & flt));
endmodule
`default_nettype wire

// File: bench/test_io_pin_function_mux.sv
// Self-checking bench for the pin function multiplexer
`timescale 1ns/100ps
`default_nettype none
module test_io_pin_function_mux;
    logic i_clk = 1'h0;
    logic i_resetn = 1'h0;
    logic [79:0] gout = '0, goe = '0, pen = '0, gpu = '0, gpd = '0;
    logic [79:0] gsl = '0, ext = '0, exten = '0;
    logic [239:0] sel = '0;
    logic irq = 1'h0, tr_en = 1'h0, swo = 1'h0, jen = 1'h0, osc_r = 1'h0;
    logic osc_o = 1'h0, usb_en = 1'h0, dp = 1'h0, usb_oe = 1'h0, dm = 1'h0;
    logic tw_o = 1'h0, tw_oe = 1'h0, sck_o = 1'h0, sck_oe = 1'h0;
    wire [79:0] pad, pout, poe_n, ppu, ppd, psl, gin;
    wire irq25, jact, jtck, osc_in, dp_in, tw_in, sck_in, rxd, ain0, ext2;
    wire jtms, jtdi, dm_in;
    int num_errors = 0;
    int check_count = 0;
    // Design under test and its board
    iomx_pin_mux DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_pad_in(pad),
        .o_pad_out(pout), .o_pad_oe_n(poe_n), .o_pad_pullup(ppu),
        .o_pad_pulldown(ppd), .o_pad_slew(psl), .i_gpio_out(gout),
        .i_gpio_oe(goe), .i_gpio_periph_en(pen), .i_gpio_func_sel(sel),
        .i_gpio_pullup(gpu), .i_gpio_pulldown(gpd), .i_gpio_slew(gsl),
        .o_gpio_in(gin), .i_gpio_irq0(irq), .o_irq_line25(irq25),
        .i_trace_en(tr_en), .i_trace_swo(swo), .i_jtag_enable(jen),
        .i_jtag_tdo(1'h0), .i_jtag_tdo_oe(1'h0), .o_jtag_active(jact),
        .o_jtag_tck(jtck), .o_jtag_tms(jtms), .o_jtag_tdi(jtdi),
        .i_main_osc_route(osc_r), .i_main_osc_out(osc_o),
        .o_main_osc_in(osc_in), .i_usb_en(usb_en), .i_usb_dp_out(dp),
        .i_usb_dm_out(dm), .i_usb_oe(usb_oe), .o_usb_dp_in(dp_in),
        .o_usb_dm_in(dm_in), .i_two_wire_data_out(tw_o),
        .i_two_wire_data_oe(tw_oe), .o_two_wire_data_in(tw_in),
        .i_serial_port0_clk_out(sck_o), .i_serial_port0_clk_oe(sck_oe),
        .o_serial_port0_clk_in(sck_in), .o_serial_port0_rxd(rxd),
        .o_analog_input0_sel(ain0), .o_ext_irq_line2(ext2));
    iomx_pad_model PADS (.i_clk(i_clk), .i_out(pout), .i_oe_n(poe_n),
        .i_pullup(ppu), .i_pulldown(ppd), .i_ext(ext), .i_ext_en(exten),
        .o_level(pad));
    // 20 MHz clock
    always #25 i_clk = ~i_clk;
    task automatic chk(input string nm, input logic [79:0] e, g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Waits land 1 ns past the edge so its updates have settled
    task automatic w(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic t_gpio;
        @(posedge i_clk);
        goe[5] <= 1'h1;
        gout[5] <= 1'h1;
        gpu <= {5{16'h1234}};
        gpd <= {5{16'h8421}};
        gsl <= {5{16'h0f0f}};
        exten[7] <= 1'h1;
        ext[7] <= 1'h1;
        w(4);
        chk("drive5", 2'h1, {poe_n[5], pout[5]});
        chk("pullup", {5{16'h1234}}, ppu);
        chk("pulldown", {5{16'h8421}}, ppd);
        chk("slew", {5{16'h0f0f}}, psl);
        chk("in7", 1'h1, gin[7]);
        @(posedge i_clk);
        pen[5] <= 1'h1;
        sel[17:15] <= 3'h7;
        exten[5] <= 1'h1;
        ext[5] <= 1'h1;
        w(4);
        chk("empty5", 1'h1, poe_n[5]);
        chk("in5", 1'h1, gin[5]);
    endtask
    task automatic t_trace;
        @(posedge i_clk);
        goe[23] <= 1'h1;
        tr_en <= 1'h1;
        swo <= 1'h1;
        w(2);
        chk("trace", 2'h1, {poe_n[23], pout[23]});
    endtask
    task automatic t_two_wire;
        @(posedge i_clk);
        pen[32] <= 1'h1;
        tw_oe <= 1'h1;
        w(2);
        chk("twd_low", 2'h0, {poe_n[32], pout[32]});
        @(posedge i_clk);
        tw_o <= 1'h1;
        w(4);
        chk("twd_rel", 1'h1, poe_n[32]);
        chk("twd_in", 1'h1, tw_in);
        @(posedge i_clk);
        sel[98:96] <= 3'h1;
        exten[32] <= 1'h1;
        w(4);
        chk("rxd", 1'h0, rxd);
        @(posedge i_clk);
        pen[32] <= 1'h0;
        exten[32] <= 1'h0;
        goe[32] <= 1'h1;
        gout[32] <= 1'h1;
        w(2);
        chk("push_pull", 2'h1, {poe_n[32], pout[32]});
    endtask
    task automatic t_line4;
        @(posedge i_clk);
        pen[4] <= 1'h1;
        sel[14:12] <= 3'h2;
        exten[4] <= 1'h1;
        ext[4] <= 1'h1;
        w(4);
        chk("irq2", 2'h2, {ext2, ain0});
        @(posedge i_clk);
        sel[14:12] <= 3'h1;
        exten[4] <= 1'h0;
        sck_oe <= 1'h1;
        w(4);
        chk("sck", 4'h0, {poe_n[4], pout[4], sck_in, ext2});
        @(posedge i_clk);
        sel[14:12] <= 3'h0;
        w(2);
        chk("ain0", 2'h3, {poe_n[4], ain0});
    endtask
    task automatic t_jtag;
        int n;
        @(posedge i_clk);
        gpu <= '0;
        exten[40] <= 1'h1;
        w(4);
        // TCK held low through both sync stages before enabling
        @(posedge i_clk);
        jen <= 1'h1;
        w(4);
        chk("no_edge", 1'h0, jact);
        @(posedge i_clk);
        ext[40] <= 1'h1;
        for (n = 0; n < 8 && jact !== 1'h1; n++) begin
            w(1);
        end
        if (n == 8) begin
            num_errors++;
            $display("BAD jtag_wait expected 1 seen 0");
            stop_test;
        end
        chk("jtag_pu", 3'h7, {ppu[42:41], jtck});
        w(3);
        chk("jtag_pins", 2'h3, {jtms, jtdi});
        @(posedge i_clk);
        jen <= 1'h0;
        goe[41] <= 1'h1;
        gout[41] <= 1'h1;
        w(3);
        chk("jtag_off", 3'h1, {jact, poe_n[41], pout[41]});
    endtask
    task automatic t_misc;
        @(posedge i_clk);
        osc_r <= 1'h1;
        osc_o <= 1'h1;
        goe[1:0] <= 2'h3;
        exten[0] <= 1'h1;
        ext[0] <= 1'h1;
        usb_en <= 1'h1;
        usb_oe <= 1'h1;
        dp <= 1'h1;
        dm <= 1'h1;
        irq <= 1'h1;
        @(posedge i_clk);
        irq <= 1'h0;
        #1;
        chk("irq_hi", 1'h1, irq25);
        w(1);
        chk("irq_lo", 1'h0, irq25);
        w(3);
        chk("osc_pads", 4'h6, {poe_n[1:0], pout[1:0]});
        chk("osc_in", 1'h1, osc_in);
        chk("usb_pads", 4'h3, {poe_n[26:25], pout[26:25]});
        chk("usb_dp_in", 1'h1, dp_in);
        chk("usb_dm_in", 1'h1, dm_in);
    endtask
    initial begin
        w(3);
        chk("rst_oe_n", '1, poe_n);
        chk("rst_pu", 80'h1 << 40, ppu);
        chk("rst_slew", '1, psl);
        @(posedge i_clk);
        i_resetn <= 1'h1;
        t_gpio;
        t_trace;
        t_two_wire;
        t_line4;
        t_jtag;
        t_misc;
        stop_test;
    end
endmodule
`default_nettype wire
